// >>> rtl/gcfg_cfg.svh
// Offsets, field positions, reset values and timing of the graphics configuration header registers.
`ifndef GCFG_CFG_SVH
`define GCFG_CFG_SVH
// ----------------------------------------------------------------
// Register indices; the APB byte address is four times the index.
// ----------------------------------------------------------------
`define GCFG_IDX_HEADER_KIND 6'h0E
`define GCFG_IDX_SELF_TEST   6'h0F
`define GCFG_IDX_APERTURE    6'h10
`define GCFG_IDX_WINDOW      6'h14
`define GCFG_IDX_MAKER       6'h2C
`define GCFG_IDX_SUBSYS      6'h2E
// ----------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------
`define GCFG_AP_BASE_HI      31
`define GCFG_AP_BASE_LO      26
`define GCFG_AP_SIZE_BIT     25
`define GCFG_AP_PREF_BIT     3
`define GCFG_WIN_BASE_HI     31
`define GCFG_WIN_BASE_LO     19
`define GCFG_TEST_SUPP_BIT   7
// ----------------------------------------------------------------
// Reset and fixed values.
// ----------------------------------------------------------------
`define GCFG_VAL_HEADER_KIND 8'h00
`define GCFG_VAL_SELF_TEST   8'h00
`define GCFG_RST_AP_BASE     6'h00
`define GCFG_RST_AP_SIZE     1'b0
`define GCFG_RST_WIN_BASE    13'h0000
`define GCFG_RST_ID          16'h0000
`define GCFG_RST_WORD        32'h00000000
// ----------------------------------------------------------------
// Timing: read data is ready one cycle after the setup cycle.
// ----------------------------------------------------------------
`define GCFG_APB_WAIT_CYCLES 0
`endif

// >>> rtl/gcfg_pkg.sv
// Types shared by the graphics configuration header register bank.
package gcfg_pkg;

   typedef struct packed
   {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
      logic [3:0]  pstrb;
   } gcfg_apb_req_t;

   typedef struct packed
   {
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
   } gcfg_apb_rsp_t;

   typedef enum logic [6:0]
   {
      GCFG_SEL_NONE        = 7'b0000001,
      GCFG_SEL_HEADER_KIND = 7'b0000010,
      GCFG_SEL_SELF_TEST   = 7'b0000100,
      GCFG_SEL_APERTURE    = 7'b0001000,
      GCFG_SEL_WINDOW      = 7'b0010000,
      GCFG_SEL_MAKER       = 7'b0100000,
      GCFG_SEL_SUBSYS      = 7'b1000000
   } gcfg_sel_t;

endpackage : gcfg_pkg

// >>> rtl/gcfg_regs.sv
// Configuration header registers of the integrated graphics function, reached over APB.
//
// The APB slave port was left to the implementer.
`include "gcfg_cfg.svh"

// What this block does
// [R1] Header kind register reads 00h always and ignores writes.
// [R2] Self-test register bit 7 reads 0, no self test; bits 6:0 reserved.
// [R3] Aperture base bits 31:26 are stored and decode address bits 31:26.
// [R4] Aperture bit 25: select 0 reads 0 (64 MB); select 1 writable (32 MB).
// [R5] Aperture bits 24:4 read zero and ignore writes.
// [R6] Aperture bit 3 reads 1, prefetchable.
// [R7] Aperture bits 2:0 read 0: 32-bit memory-space decoder.
// [R8] Window base bits 31:19 are stored; a 512 KB window is decoded.
// [R9] Window bits 18:4 read zero and ignore writes.
// [R10] Window bits 3:0 read 0: not prefetchable, 32-bit memory space.
// [R11] Maker code resets to 0000h, takes one write, then locks until reset.
// [R12] Subsystem code resets to 0000h, locks after its first write until reset.
// [R13] Boot firmware should program both identity registers early during start-up.
// [R14] Writes to fixed or reserved bits are ignored; reserved bits read zero.
module gcfg_regs
(
   input  logic                    CLK,
   input  logic                    RST_B,
   input  logic                    CE,
   input  gcfg_pkg::gcfg_apb_req_t APB_REQ,
   output gcfg_pkg::gcfg_apb_rsp_t APB_RSP,
   input  logic                    APERTURE_SIZE_SELECT_SOURCE,
   input  logic [31:0]             MEM_ADDR,
   output logic                    APERTURE_HIT,
   output logic                    WINDOW_HIT
);
   import gcfg_pkg::*;

   // ----------------------------------------------------------------
   // Declarations.
   // ----------------------------------------------------------------
   gcfg_sel_t   sel;
   logic        setup_phase;
   logic        wr_access;
   logic [5:0]  ap_base_reg;
   logic [5:0]  ap_base_next;
   logic        ap_size_reg;
   logic        ap_size_next;
   logic [12:0] win_base_reg;
   logic [12:0] win_base_next;
   logic [15:0] maker_reg;
   logic [15:0] maker_next;
   logic        maker_lock_reg;
   logic        maker_lock_next;
   logic [15:0] subsys_reg;
   logic [15:0] subsys_next;
   logic        subsys_lock_reg;
   logic        subsys_lock_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic        err_reg;
   logic        err_next;
   logic        ap_hit_reg;
   logic        ap_hit_next;
   logic        win_hit_reg;
   logic        win_hit_next;
   logic [31:0] ap_word;
   logic [31:0] win_word;

   // ----------------------------------------------------------------
   // Byte-lane merge of a 16-bit field.
   // ----------------------------------------------------------------
   function automatic logic [15:0] merge16
   (
      input logic [15:0] old_val,
      input logic [15:0] new_val,
      input logic [1:0]  strb
   );
      logic [15:0] res;
      res = old_val;
      if (strb[0])
      begin
         res[7:0] = new_val[7:0];
      end
      if (strb[1])
      begin
         res[15:8] = new_val[15:8];
      end
      return res;
   endfunction : merge16

   // ----------------------------------------------------------------
   // Address decode.
   // ----------------------------------------------------------------
   assign setup_phase = APB_REQ.psel & ~APB_REQ.penable;
   assign wr_access   = APB_REQ.psel & APB_REQ.penable & APB_REQ.pwrite;

   always_comb
   begin
      sel = GCFG_SEL_NONE;
      if (APB_REQ.paddr[1:0] == 2'h0)
      begin
         case (APB_REQ.paddr[7:2])
            `GCFG_IDX_HEADER_KIND: sel = GCFG_SEL_HEADER_KIND;
            `GCFG_IDX_SELF_TEST:   sel = GCFG_SEL_SELF_TEST;
            `GCFG_IDX_APERTURE:    sel = GCFG_SEL_APERTURE;
            `GCFG_IDX_WINDOW:      sel = GCFG_SEL_WINDOW;
            `GCFG_IDX_MAKER:       sel = GCFG_SEL_MAKER;
            `GCFG_IDX_SUBSYS:      sel = GCFG_SEL_SUBSYS;
            default:               sel = GCFG_SEL_NONE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Read views of the two base registers.
   // ----------------------------------------------------------------
   always_comb
   begin
      ap_word = `GCFG_RST_WORD; // [R5] [R7] [R14]
      ap_word[`GCFG_AP_BASE_HI:`GCFG_AP_BASE_LO] = ap_base_reg; // [R3]
      ap_word[`GCFG_AP_SIZE_BIT] = ap_size_reg & APERTURE_SIZE_SELECT_SOURCE; // [R4]
      ap_word[`GCFG_AP_PREF_BIT] = 1'b1; // [R6]
      win_word = `GCFG_RST_WORD; // [R9] [R10] [R14]
      win_word[`GCFG_WIN_BASE_HI:`GCFG_WIN_BASE_LO] = win_base_reg; // [R8]
   end

   // ----------------------------------------------------------------
   // Register writes.
   // ----------------------------------------------------------------
   always_comb
   begin
      ap_base_next     = ap_base_reg;
      ap_size_next     = ap_size_reg;
      win_base_next    = win_base_reg;
      maker_next       = maker_reg;
      maker_lock_next  = maker_lock_reg;
      subsys_next      = subsys_reg;
      subsys_lock_next = subsys_lock_reg;
      if (wr_access)
      begin
         unique case (sel)
            GCFG_SEL_APERTURE:
            begin
               if (APB_REQ.pstrb[3])
               begin
                  ap_base_next = APB_REQ.pwdata[`GCFG_AP_BASE_HI:`GCFG_AP_BASE_LO]; // [R3]
                  if (APERTURE_SIZE_SELECT_SOURCE)
                  begin
                     ap_size_next = APB_REQ.pwdata[`GCFG_AP_SIZE_BIT]; // [R4]
                  end
               end
            end
            GCFG_SEL_WINDOW:
            begin
               if (APB_REQ.pstrb[3])
               begin
                  win_base_next[12:5] = APB_REQ.pwdata[31:24]; // [R8]
               end
               if (APB_REQ.pstrb[2])
               begin
                  win_base_next[4:0] = APB_REQ.pwdata[23:19]; // [R8]
               end
            end
            GCFG_SEL_MAKER:
            begin
               // Any write locks, even one with no byte enabled.
               if (!maker_lock_reg)
               begin
                  maker_next      = merge16(maker_reg, APB_REQ.pwdata[15:0], APB_REQ.pstrb[1:0]); // [R11]
                  maker_lock_next = 1'b1; // [R11]
               end
            end
            GCFG_SEL_SUBSYS:
            begin
               if (!subsys_lock_reg)
               begin
                  subsys_next      = merge16(subsys_reg, APB_REQ.pwdata[15:0], APB_REQ.pstrb[1:0]); // [R12]
                  subsys_lock_next = 1'b1; // [R12]
               end
            end
            GCFG_SEL_HEADER_KIND, GCFG_SEL_SELF_TEST, GCFG_SEL_NONE:
            begin
               // Fixed registers take no writes.
               ap_base_next = ap_base_reg; // [R1] [R2] [R14]
            end
            default:
            begin
               ap_base_next = ap_base_reg;
            end
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         ap_base_reg     <= `GCFG_RST_AP_BASE;
         ap_size_reg     <= `GCFG_RST_AP_SIZE;
         win_base_reg    <= `GCFG_RST_WIN_BASE;
         maker_reg       <= `GCFG_RST_ID; // [R11]
         maker_lock_reg  <= 1'b0;
         subsys_reg      <= `GCFG_RST_ID; // [R12]
         subsys_lock_reg <= 1'b0;
      end
      else if (CE)
      begin
         ap_base_reg     <= ap_base_next;
         ap_size_reg     <= ap_size_next;
         win_base_reg    <= win_base_next;
         maker_reg       <= maker_next;
         maker_lock_reg  <= maker_lock_next;
         subsys_reg      <= subsys_next;
         subsys_lock_reg <= subsys_lock_next;
      end
   end

   // ----------------------------------------------------------------
   // Read data and error, captured in the setup cycle.
   // ----------------------------------------------------------------
   // Capturing at setup keeps the data output registered at no cost in wait states.
   always_comb
   begin
      rdata_next = rdata_reg;
      err_next   = err_reg;
      if (setup_phase)
      begin
         err_next   = (sel == GCFG_SEL_NONE);
         rdata_next = `GCFG_RST_WORD;
         unique case (sel)
            GCFG_SEL_HEADER_KIND:
            begin
               rdata_next[7:0] = `GCFG_VAL_HEADER_KIND; // [R1]
            end
            GCFG_SEL_SELF_TEST:
            begin
               rdata_next[7:0] = `GCFG_VAL_SELF_TEST; // [R2]
               rdata_next[`GCFG_TEST_SUPP_BIT] = 1'b0; // [R2]
            end
            GCFG_SEL_APERTURE:
            begin
               rdata_next = ap_word;
            end
            GCFG_SEL_WINDOW:
            begin
               rdata_next = win_word;
            end
            GCFG_SEL_MAKER:
            begin
               rdata_next[15:0] = maker_reg;
            end
            GCFG_SEL_SUBSYS:
            begin
               rdata_next[15:0] = subsys_reg;
            end
            GCFG_SEL_NONE:
            begin
               rdata_next = `GCFG_RST_WORD;
            end
            default:
            begin
               rdata_next = `GCFG_RST_WORD;
            end
         endcase
      end
   end

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         rdata_reg <= `GCFG_RST_WORD;
         err_reg   <= 1'b0;
      end
      else if (CE)
      begin
         rdata_reg <= rdata_next;
         err_reg   <= err_next;
      end
   end

   // ----------------------------------------------------------------
   // Memory decode of the aperture and the register window.
   // ----------------------------------------------------------------
   always_comb
   begin
      ap_hit_next = (MEM_ADDR[`GCFG_AP_BASE_HI:`GCFG_AP_BASE_LO] == ap_base_reg); // [R3]
      if (APERTURE_SIZE_SELECT_SOURCE)
      begin
         ap_hit_next = ap_hit_next & (MEM_ADDR[`GCFG_AP_SIZE_BIT] == ap_size_reg); // [R4]
      end
      win_hit_next = (MEM_ADDR[`GCFG_WIN_BASE_HI:`GCFG_WIN_BASE_LO] == win_base_reg); // [R8]
   end

   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         ap_hit_reg  <= 1'b0;
         win_hit_reg <= 1'b0;
      end
      else if (CE)
      begin
         ap_hit_reg  <= ap_hit_next;
         win_hit_reg <= win_hit_next;
      end
   end

   // ----------------------------------------------------------------
   // Outputs.
   // ----------------------------------------------------------------
   // A frozen clock enable also holds pready low so no access completes unseen.
   assign APB_RSP.pready  = APB_REQ.psel & APB_REQ.penable & CE;
   assign APB_RSP.prdata  = rdata_reg;
   assign APB_RSP.pslverr = APB_REQ.psel & APB_REQ.penable & err_reg;
   assign APERTURE_HIT    = ap_hit_reg;
   assign WINDOW_HIT      = win_hit_reg;

endmodule : gcfg_regs

// >>> tb/gcfg_checker.sv
// Concurrent checks of the graphics configuration header registers at the top ports.
module gcfg_checker
(
   input logic                    CLK,
   input logic                    RST_B,
   input logic                    CE,
   input gcfg_pkg::gcfg_apb_req_t APB_REQ,
   input gcfg_pkg::gcfg_apb_rsp_t APB_RSP,
   input logic                    APERTURE_SIZE_SELECT_SOURCE,
   input logic [31:0]             MEM_ADDR,
   input logic                    APERTURE_HIT,
   input logic                    WINDOW_HIT
);
   timeunit 1ns;
   timeprecision 1ps;
   import gcfg_pkg::*;
   // ------------------------------------------------------------
   // Shadow of the stored bases, built from completed writes.
   // ------------------------------------------------------------
   logic        rd_done;
   logic        wr_done;
   logic [5:0]  ap_reg;
   logic [5:0]  ap_next;
   logic [12:0] win_reg;
   logic [12:0] win_next;
   logic        ap_match;
   logic        win_match;
   logic        ap25_reg;
   logic        ap25_next;
   logic        ap32_match;
   logic        map_hit;
   always_comb
   begin
      rd_done = APB_REQ.psel & APB_REQ.penable & APB_RSP.pready & ~APB_REQ.pwrite;
      wr_done = APB_REQ.psel & APB_REQ.penable & APB_RSP.pready & APB_REQ.pwrite;
      ap_next = ap_reg;
      win_next = win_reg;
      ap25_next = ap25_reg;
      if (wr_done && APB_REQ.paddr == 8'h40 && APB_REQ.pstrb[3])
         ap_next = APB_REQ.pwdata[31:26];
      // Bit 25 is only taken while the select allows the 32 MB layout.
      if (wr_done && APB_REQ.paddr == 8'h40 && APB_REQ.pstrb[3] && APERTURE_SIZE_SELECT_SOURCE)
         ap25_next = APB_REQ.pwdata[25];
      if (wr_done && APB_REQ.paddr == 8'h50 && APB_REQ.pstrb[3])
         win_next[12:5] = APB_REQ.pwdata[31:24];
      if (wr_done && APB_REQ.paddr == 8'h50 && APB_REQ.pstrb[2])
         win_next[4:0] = APB_REQ.pwdata[23:19];
      ap_match = MEM_ADDR[31:26] == ap_reg;
      ap32_match = ap_match && (MEM_ADDR[25] == ap25_reg);
      win_match = MEM_ADDR[31:19] == win_reg;
      map_hit = APB_REQ.paddr inside {8'h38, 8'h3C, 8'h40, 8'h50, 8'hB0, 8'hB8};
   end
   always_ff @(posedge CLK or negedge RST_B)
   begin
      if (!RST_B)
      begin
         ap_reg <= 6'h00;
         win_reg <= 13'h0000;
         ap25_reg <= 1'b0;
      end
      else
      begin
         ap_reg <= ap_next;
         win_reg <= win_next;
         ap25_reg <= ap25_next;
      end
   end
   // ------------------------------------------------------------
   // Properties.
   // ------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);
   sequence s_read(logic [7:0] a);
      rd_done && APB_REQ.paddr == a;
   endsequence
   property p_hdr; s_read(8'h38) |-> APB_RSP.prdata == 32'h00000000; endproperty
   a_hdr: assert property (p_hdr) else $error("header kind not zero");
   property p_test; s_read(8'h3C) |-> APB_RSP.prdata == 32'h00000000; endproperty
   a_test: assert property (p_test) else $error("self test word not zero");
   property p_ap_low; s_read(8'h40) |-> APB_RSP.prdata[24:0] == 25'h0000008; endproperty
   a_ap_low: assert property (p_ap_low) else $error("aperture fixed bits wrong");
   property p_ap_size;
      s_read(8'h40) ##0 !$past(APERTURE_SIZE_SELECT_SOURCE) |-> !APB_RSP.prdata[25];
   endproperty
   a_ap_size: assert property (p_ap_size) else $error("aperture bit 25 set with select low");
   property p_win_low; s_read(8'h50) |-> APB_RSP.prdata[18:0] == 19'h00000; endproperty
   a_win_low: assert property (p_win_low) else $error("window fixed bits wrong");
   property p_id_hi; s_read(8'hB0) |-> APB_RSP.prdata[31:16] == 16'h0000; endproperty
   a_id_hi: assert property (p_id_hi) else $error("maker code upper half not zero");
   property p_err; rd_done || wr_done |-> APB_RSP.pslverr == !map_hit; endproperty
   a_err: assert property (p_err) else $error("slave error does not match address map");
   // With select high bit 25 joins the compare, so the two sizes are checked apart.
   property p_ap_hit; CE && !APERTURE_SIZE_SELECT_SOURCE |=> APERTURE_HIT == $past(ap_match); endproperty
   a_ap_hit: assert property (p_ap_hit) else $error("aperture decode wrong");
   property p_ap_hit32;
      CE && APERTURE_SIZE_SELECT_SOURCE |=> APERTURE_HIT == $past(ap32_match);
   endproperty
   a_ap_hit32: assert property (p_ap_hit32) else $error("aperture decode with bit 25 wrong");
   property p_win_hit; CE |=> WINDOW_HIT == $past(win_match); endproperty
   a_win_hit: assert property (p_win_hit) else $error("window decode wrong");
endmodule : gcfg_checker

bind gcfg_regs gcfg_checker chk_u (.CLK(CLK), .RST_B(RST_B), .CE(CE), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP),
   .APERTURE_SIZE_SELECT_SOURCE(APERTURE_SIZE_SELECT_SOURCE), .MEM_ADDR(MEM_ADDR),
   .APERTURE_HIT(APERTURE_HIT), .WINDOW_HIT(WINDOW_HIT));

// >>> tb/gfx_config_header_regs_bench.sv
// Self-checking bench for the graphics configuration header registers.
module gfx_config_header_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;
   import gcfg_pkg::*;
   logic          clk;
   logic          rst_b;
   logic          ce;
   logic          sel;
   logic [31:0]   mem_addr;
   logic          ap_hit;
   logic          win_hit;
   gcfg_apb_req_t req;
   gcfg_apb_rsp_t rsp;
   logic [31:0]   exp_q[$];
   logic [31:0]   d;
   int            seed;
   int            err_total;
   int            comparisons;
   int            cyc;
   logic [7:0]    addrs[6] = '{8'h38, 8'h3C, 8'h40, 8'h50, 8'hB0, 8'hB8};
   logic [31:0]   rstv[6]  = '{32'h0, 32'h0, 32'h8, 32'h0, 32'h0, 32'h0};
   logic [31:0]   ma[4]    = '{32'hA7FFFFF0, 32'h12387FF0, 32'h08000000, 32'hA5FFFFF0};
   logic [1:0]    hx[4]    = '{2'b10, 2'b01, 2'b00, 2'b10};
   gcfg_regs dut_u (.CLK(clk), .RST_B(rst_b), .CE(ce), .APB_REQ(req), .APB_RSP(rsp),
      .APERTURE_SIZE_SELECT_SOURCE(sel), .MEM_ADDR(mem_addr), .APERTURE_HIT(ap_hit), .WINDOW_HIT(win_hit));
   // ------------------------------------------------------------
   // Tasks.
   // ------------------------------------------------------------
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp)
      begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
      end
   endtask : chk
   task automatic give_verdict;
      if (err_total == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : give_verdict
   // The read's expectation is queued at setup so the monitor always finds it first.
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] s,
                      input logic [31:0] ex);
      @(posedge clk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: wd, pstrb: s};
      if (!w)
         exp_q.push_back(ex);
      @(posedge clk);
      req.penable <= 1'b1;
      do
         @(posedge clk);
      while (rsp.pready !== 1'b1);
      req <= '0;
   endtask : apb
   // ------------------------------------------------------------
   // Clock, monitor and sequence.
   // ------------------------------------------------------------
   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_total++;
         give_verdict;
      end
      if (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite)
         chk("prdata", exp_q.pop_front(), rsp.prdata);
   end
   initial
   begin
      seed = 9255;
      rst_b = 1'b0;
      ce = 1'b1;
      sel = 1'b0;
      mem_addr = '0;
      req = '0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      foreach (addrs[i]) apb(1'b0, addrs[i], '0, 4'h0, rstv[i]);
      for (int i = 0; i < 2; i++)
      begin
         apb(1'b1, addrs[i], $random(seed), 4'hF, '0);
         apb(1'b0, addrs[i], '0, 4'h0, 32'h0);
      end
      d = $random(seed);
      apb(1'b1, 8'h40, d | 32'h02000000, 4'hF, '0);
      apb(1'b0, 8'h40, '0, 4'h0, {d[31:26], 26'h8});
      sel <= 1'b1;
      apb(1'b1, 8'h40, d | 32'h02000000, 4'hF, '0);
      apb(1'b0, 8'h40, '0, 4'h0, {d[31:26], 26'h2000008});
      sel <= 1'b0;
      apb(1'b0, 8'h40, '0, 4'h0, {d[31:26], 26'h8});
      d = $random(seed);
      apb(1'b1, 8'h50, d, 4'hF, '0);
      apb(1'b0, 8'h50, '0, 4'h0, {d[31:19], 19'h0});
      apb(1'b1, 8'h50, ~d, 4'h4, '0);
      apb(1'b0, 8'h50, '0, 4'h0, {d[31:24], ~d[23:19], 19'h0});
      for (int i = 4; i < 6; i++)
      begin
         d = $random(seed);
         apb(1'b1, addrs[i], d, 4'hF, '0);
         apb(1'b1, addrs[i], ~d, 4'hF, '0);
         apb(1'b0, addrs[i], '0, 4'h0, {16'h0, d[15:0]});
      end
      apb(1'b0, 8'h44, '0, 4'h0, 32'h0);
      apb(1'b1, 8'h40, 32'hA4000000, 4'hF, '0);
      apb(1'b1, 8'h50, 32'h12380000, 4'hF, '0);
      for (int i = 0; i < 4; i++)
      begin
         mem_addr <= ma[i];
         repeat (2) @(posedge clk);
         chk("hits", {30'h0, hx[i]}, {30'h0, ap_hit, win_hit});
      end
      // Random select here lets the checker see the 32 MB decode, including a bit 25 miss.
      repeat (40)
      begin
         mem_addr <= ma[{$random(seed)} % 4];
         ce <= |($random(seed) & 3);
         sel <= ^$random(seed);
         @(posedge clk);
      end
      ce <= 1'b1;
      sel <= 1'b0;
      rst_b <= 1'b0;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      apb(1'b0, 8'hB0, '0, 4'h0, 32'h0);
      apb(1'b1, 8'hB0, 32'h00005A3C, 4'hF, '0);
      apb(1'b0, 8'hB0, '0, 4'h0, 32'h00005A3C);
      give_verdict;
   end
endmodule : gfx_config_header_regs_bench
